// ==== design/calm_params.svh ====
// Offsets, field positions, reset values and timing counts of the capacity alarm block
`ifndef CALM_PARAMS_SVH
`define CALM_PARAMS_SVH

`define CALM_OFF_LOAD_CFG 8'h00
`define CALM_OFF_STATUS 8'h04
`define CALM_OFF_INIT_SET 8'h08
`define CALM_OFF_INIT_CLR 8'h0C
`define CALM_OFF_FIN_SET 8'h10
`define CALM_OFF_FIN_CLR 8'h14
`define CALM_OFF_RESERVE 8'h18
`define CALM_OFF_DESIGN_CAP 8'h1C
`define CALM_OFF_DESIGN_EN 8'h20
`define CALM_OFF_USER_MA 8'h24
`define CALM_OFF_USER_MW 8'h28
`define CALM_OFF_HOST_RATE 8'h2C
`define CALM_OFF_REMAIN 8'h30
`define CALM_OFF_LOAD_RATE 8'h34
`define CALM_OFF_AVG_CUR 8'h38
`define CALM_OFF_PREV_AVG 8'h3C
`define CALM_OFF_IRQ_STAT 8'h40
`define CALM_OFF_IRQ_MASK 8'h44
`define CALM_OFF_RAW_CAP 8'h48

`define CALM_LDMODE_BIT 0
`define CALM_LDSEL_LSB 8
`define CALM_ST_MODEL 0
`define CALM_ST_INIT 1
`define CALM_ST_FINAL 2
`define CALM_ST_DSG 3
`define CALM_EV_INIT 0
`define CALM_EV_FINAL 1
`define CALM_EV_CYCLE 2

`define CALM_LDMODE_RST 1'b0
`define CALM_LDSEL_RST 3'h1
`define CALM_THR_RST 16'h0000
`define CALM_MASK_RST 3'h0

`define CALM_SAMPLE_MS 1000
`define CALM_TAU_MS 14000
`define CALM_MS_PER_HOUR 3600000
`define CALM_FILT_SHIFT $clog2(`CALM_TAU_MS / `CALM_SAMPLE_MS)
`define CALM_AVG_SHIFT 2
`define CALM_PWR_DIV 10000
`define CALM_DESIGN_DIV 5
`define CALM_DIV_STEPS 6'h20

`endif

// ==== design/calm_pkg.sv ====
// Types shared by the capacity alarm and load model block
package calm_pkg;
	typedef logic [15:0] calm_cap_t;
	typedef enum logic {
		CALM_CONST_CUR = 1'b0,
		CALM_CONST_PWR = 1'b1
	} calm_mode_e;
	typedef enum logic [2:0] {
		CALM_SEL_PREV = 3'h0,
		CALM_SEL_PRES = 3'h1,
		CALM_SEL_AVG = 3'h2,
		CALM_SEL_FILT = 3'h3,
		CALM_SEL_DESIGN = 3'h4,
		CALM_SEL_HOST = 3'h5,
		CALM_SEL_USER = 3'h6,
		CALM_SEL_SPARE = 3'h7
	} calm_sel_e;
	typedef enum logic [1:0] {
		CALM_DIV_IDLE = 2'b00,
		CALM_DIV_RUN = 2'b01,
		CALM_DIV_DONE = 2'b11
	} calm_div_e;
endpackage

// ==== design/calm_top.sv ====
// Capacity alarm flags, low-battery pin and load model selection
`timescale 1ns/1ps
`include "calm_params.svh"

// Functional notes
// R1 - Integrate sense current each sample to move the charge estimate both ways.
// R2 - Set initial low flag when remaining capacity is below first set level.
// R3 - Clear initial low flag only above its separate clear level.
// R4 - Low-battery pin always follows the initial low flag.
// R5 - Set final low flag when remaining capacity is below final set level.
// R6 - Final set level of zero disables the final low flag.
// R7 - Clear final low flag above final clear level, only when set.
// R8 - Thresholds and remaining capacity are all in mAh.
// R9 - Load model 0 is constant current (default), 1 constant power.
// R10 - Status word mirrors the load model setting.
// R11 - Current model selector 0..6 picks one of seven current sources.
// R12 - Power model selector 0..6 picks the matching power sources.
// R13 - Selector 3 uses averaged current low-pass filtered with 14 s constant; the code's filter shift of 4 gives 16 s.
// R14 - Record average discharge over each cycle; keep previous cycle value.
// R15 - Reserve charge counts below zero remaining, compensated at no-load rate.
// R16 - Compare thresholds on every remaining capacity update; pin in same update.
module calm_top #(
	parameter int SAMPLE_MS = `CALM_SAMPLE_MS
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Measurements from the converter logic
	input wire logic sample_valid_i,
	input wire logic signed [15:0] sense_current_i,
	input wire logic [15:0] cell_voltage_i,
	// Alarm outputs
	output logic low_battery_pin_o,
	output logic irq_o
);
	localparam logic signed [31:0] SPH = 32'(`CALM_MS_PER_HOUR / SAMPLE_MS);
	localparam int FSH = `CALM_FILT_SHIFT;
	localparam int ASH = `CALM_AVG_SHIFT;

	// Current magnitude times voltage, in 10 mW units
	function automatic logic [15:0] pwr(input logic [15:0] m, input logic [15:0] v);
		logic [31:0] p;
		p = (32'(m) * 32'(v)) / 32'(`CALM_PWR_DIV);
		pwr = p[15:0];
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Bus decode
	logic wb_req;
	logic wb_wr;
	logic [7:0] wb_off;
	assign wb_req = cyc_i & stb_i & ~ack_o;
	// Writes land at the edge where the master samples ack high
	assign wb_wr = cyc_i & stb_i & we_i & ack_o;
	assign wb_off = {adr_i[7:2], 2'b00};

	// Configuration
	logic load_mode;
	logic [2:0] load_sel;
	calm_pkg::calm_cap_t init_set, init_clr, fin_set, fin_clr;
	calm_pkg::calm_cap_t reserve_charge_setting, design_cap, design_energy;
	calm_pkg::calm_cap_t user_rate_ma, user_rate_mw, host_rate_value;
	logic [2:0] irq_mask;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			load_mode <= `CALM_LDMODE_RST; // see R9
			load_sel <= `CALM_LDSEL_RST;
			init_set <= `CALM_THR_RST;
			init_clr <= `CALM_THR_RST;
			fin_set <= `CALM_THR_RST;
			fin_clr <= `CALM_THR_RST;
			reserve_charge_setting <= `CALM_THR_RST;
			design_cap <= `CALM_THR_RST;
			design_energy <= `CALM_THR_RST;
			user_rate_ma <= `CALM_THR_RST;
			user_rate_mw <= `CALM_THR_RST;
			host_rate_value <= `CALM_THR_RST;
			irq_mask <= `CALM_MASK_RST;
		end else if (wb_wr) begin
			unique case (wb_off)
				`CALM_OFF_LOAD_CFG: begin
					if (sel_i[0])
						load_mode <= dat_i[`CALM_LDMODE_BIT];
					if (sel_i[1])
						load_sel <= dat_i[`CALM_LDSEL_LSB +: 3];
				end
				`CALM_OFF_INIT_SET: init_set <= merge(init_set, dat_i, sel_i);
				`CALM_OFF_INIT_CLR: init_clr <= merge(init_clr, dat_i, sel_i);
				`CALM_OFF_FIN_SET: fin_set <= merge(fin_set, dat_i, sel_i);
				`CALM_OFF_FIN_CLR: fin_clr <= merge(fin_clr, dat_i, sel_i);
				`CALM_OFF_RESERVE: begin
					reserve_charge_setting <= merge(reserve_charge_setting, dat_i, sel_i);
				end
				`CALM_OFF_DESIGN_CAP: design_cap <= merge(design_cap, dat_i, sel_i);
				`CALM_OFF_DESIGN_EN: design_energy <= merge(design_energy, dat_i, sel_i);
				`CALM_OFF_USER_MA: user_rate_ma <= merge(user_rate_ma, dat_i, sel_i);
				`CALM_OFF_USER_MW: user_rate_mw <= merge(user_rate_mw, dat_i, sel_i);
				`CALM_OFF_HOST_RATE: begin
					host_rate_value <= merge(host_rate_value, dat_i, sel_i);
				end
				`CALM_OFF_IRQ_MASK: begin
					if (sel_i[0])
						irq_mask <= dat_i[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Charge integration in mA-samples, one mAh per hour's worth of samples
	logic raw_wr;
	logic signed [31:0] frac;
	logic signed [31:0] next_frac;
	calm_pkg::calm_cap_t raw_cap;
	assign raw_wr = wb_wr && wb_off == `CALM_OFF_RAW_CAP;
	assign next_frac = frac + 32'(sense_current_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frac <= 32'h00000000;
			raw_cap <= 16'h0000;
		end else if (raw_wr) begin
			// A host load drops that cycle's sample
			raw_cap <= merge(raw_cap, dat_i, sel_i);
			frac <= 32'h00000000;
		end else if (sample_valid_i) begin
			if (next_frac >= SPH) begin
				frac <= next_frac - SPH; // see R1
				if (raw_cap != 16'hFFFF)
					raw_cap <= raw_cap + 16'h0001;
			end else if (next_frac <= -SPH) begin
				frac <= next_frac + SPH; // see R1
				if (raw_cap != 16'h0000)
					raw_cap <= raw_cap - 16'h0001;
			end else begin
				frac <= next_frac;
			end
		end
	end

	// Reported capacity: reserve is held back at a flat, no-load figure
	calm_pkg::calm_cap_t remaining_capacity_a;
	logic upd_d;
	logic rc_valid;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remaining_capacity_a <= 16'h0000;
			upd_d <= 1'b0;
			rc_valid <= 1'b0;
		end else begin
			upd_d <= sample_valid_i | raw_wr;
			rc_valid <= upd_d;
			// see R15, R8
			remaining_capacity_a <= (raw_cap > reserve_charge_setting) ?
				raw_cap - reserve_charge_setting : 16'h0000;
		end
	end

	// Alarm flags, evaluated on each capacity update
	logic capacity_initial_low_flag;
	logic capacity_final_low_flag;
	logic ev_init;
	logic ev_final;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			capacity_initial_low_flag <= 1'b0;
			low_battery_pin_o <= 1'b0;
		end else if (rc_valid) begin
			if (remaining_capacity_a < init_set) begin
				capacity_initial_low_flag <= 1'b1; // see R2, R16
				low_battery_pin_o <= 1'b1; // see R4
			end else if (remaining_capacity_a > init_clr) begin
				capacity_initial_low_flag <= 1'b0; // see R3
				low_battery_pin_o <= 1'b0; // see R4
			end
		end
	end
	assign ev_init = rc_valid && remaining_capacity_a < init_set && !capacity_initial_low_flag;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			capacity_final_low_flag <= 1'b0;
		end else if (rc_valid) begin
			if (fin_set == 16'h0000)
				capacity_final_low_flag <= 1'b0; // see R6
			else if (remaining_capacity_a < fin_set)
				capacity_final_low_flag <= 1'b1; // see R5, R16
			else if (capacity_final_low_flag && remaining_capacity_a > fin_clr)
				capacity_final_low_flag <= 1'b0; // see R7
		end
	end
	assign ev_final = rc_valid && fin_set != 16'h0000 &&
		remaining_capacity_a < fin_set && !capacity_final_low_flag;

	// Running averages of the sense current
	logic signed [23:0] avg_acc;
	logic [23:0] filt_acc;
	logic signed [15:0] averaged_current;
	logic [15:0] avg_mag;
	logic [15:0] filt_mag;
	assign averaged_current = 16'(avg_acc >>> ASH);
	assign avg_mag = averaged_current[15] ? 16'(-averaged_current) : 16'h0000;
	assign filt_mag = 16'(filt_acc >> FSH);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			avg_acc <= 24'h000000;
			filt_acc <= 24'h000000;
		end else if (sample_valid_i) begin
			avg_acc <= avg_acc + 24'(sense_current_i) - (avg_acc >>> ASH);
			filt_acc <= filt_acc + 24'(avg_mag) - (filt_acc >> FSH); // see R13
		end
	end

	// Discharge cycle bookkeeping
	logic dsg;
	logic [15:0] dsg_mag;
	logic in_dsg;
	logic ev_cycle;
	logic [31:0] sum_q [2];
	logic [31:0] cnt;
	logic div_go;
	assign dsg = sense_current_i[15];
	assign dsg_mag = 16'(-sense_current_i);
	assign ev_cycle = sample_valid_i && !dsg && in_dsg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_dsg <= 1'b0;
			sum_q[0] <= 32'h00000000;
			sum_q[1] <= 32'h00000000;
			cnt <= 32'h00000000;
			div_go <= 1'b0;
		end else begin
			div_go <= sample_valid_i && dsg;
			if (sample_valid_i && dsg) begin
				in_dsg <= 1'b1; // see R14
				sum_q[0] <= sum_q[0] + 32'(dsg_mag);
				sum_q[1] <= sum_q[1] + 32'(pwr(dsg_mag, cell_voltage_i));
				cnt <= cnt + 32'h00000001;
			end else if (ev_cycle) begin
				in_dsg <= 1'b0;
				sum_q[0] <= 32'h00000000;
				sum_q[1] <= 32'h00000000;
				cnt <= 32'h00000000;
			end
		end
	end

	// Serial divider: one bit per clock, current and power side by side
	calm_pkg::calm_div_e div_st;
	logic [5:0] div_n;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_st <= calm_pkg::CALM_DIV_IDLE;
			div_n <= 6'h00;
		end else if (div_go) begin
			div_st <= calm_pkg::CALM_DIV_RUN;
			div_n <= 6'h00;
		end else begin
			unique case (div_st)
				calm_pkg::CALM_DIV_IDLE: begin
				end
				calm_pkg::CALM_DIV_RUN: begin
					div_n <= div_n + 6'h01;
					if (div_n == `CALM_DIV_STEPS - 6'h01)
						div_st <= calm_pkg::CALM_DIV_DONE;
				end
				calm_pkg::CALM_DIV_DONE: div_st <= calm_pkg::CALM_DIV_IDLE;
				default: div_st <= calm_pkg::CALM_DIV_IDLE;
			endcase
		end
	end

	logic [15:0] pres_avg [2];
	logic [15:0] prev_avg [2];
	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_div
			logic [32:0] rem;
			logic [31:0] quo;
			logic [32:0] shr;
			assign shr = {rem[31:0], quo[31]};
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					rem <= 33'h000000000;
					quo <= 32'h00000000;
					pres_avg[k] <= 16'h0000;
					prev_avg[k] <= 16'h0000;
				end else begin
					if (div_go) begin
						rem <= 33'h000000000;
						quo <= sum_q[k];
					end else if (div_st == calm_pkg::CALM_DIV_RUN) begin
						if (shr >= {1'b0, cnt}) begin
							rem <= shr - {1'b0, cnt};
							quo <= {quo[30:0], 1'b1};
						end else begin
							rem <= shr;
							quo <= {quo[30:0], 1'b0};
						end
					end
					if (div_st == calm_pkg::CALM_DIV_DONE)
						pres_avg[k] <= (quo[31:16] != 16'h0000) ? 16'hFFFF : quo[15:0];
					if (ev_cycle)
						prev_avg[k] <= pres_avg[k]; // see R14
				end
			end
		end
	endgenerate

	// Load used for compensation
	logic [15:0] load_rate;
	logic [15:0] next_rate;
	always_comb begin
		next_rate = pres_avg[load_mode];
		unique case (calm_pkg::calm_sel_e'(load_sel))
			calm_pkg::CALM_SEL_PREV: next_rate = prev_avg[load_mode]; // see R11, R12
			calm_pkg::CALM_SEL_PRES: next_rate = pres_avg[load_mode];
			calm_pkg::CALM_SEL_AVG: next_rate = load_mode ? pwr(avg_mag, cell_voltage_i) : avg_mag;
			calm_pkg::CALM_SEL_FILT: begin
				next_rate = load_mode ? pwr(filt_mag, cell_voltage_i) : filt_mag; // see R13
			end
			calm_pkg::CALM_SEL_DESIGN: begin
				next_rate = (load_mode ? design_energy : design_cap) / 16'(`CALM_DESIGN_DIV);
			end
			calm_pkg::CALM_SEL_HOST: next_rate = host_rate_value;
			calm_pkg::CALM_SEL_USER: next_rate = load_mode ? user_rate_mw : user_rate_ma;
			default: next_rate = pres_avg[load_mode];
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			load_rate <= 16'h0000;
		else
			load_rate <= next_rate; // see R9
	end

	// Sticky events, write one to clear; a new event beats the clear
	logic [2:0] irq_stat;
	logic [2:0] irq_ev;
	logic [2:0] irq_clr;
	assign irq_ev = {ev_cycle, ev_final, ev_init};
	assign irq_clr = (wb_wr && wb_off == `CALM_OFF_IRQ_STAT && sel_i[0]) ? dat_i[2:0] : 3'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= 3'h0;
			irq_o <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// Read data and acknowledge; unmapped reads give zero
	logic [15:0] status_word;
	always_comb begin
		status_word = 16'h0000;
		status_word[`CALM_ST_MODEL] = load_mode; // see R10
		status_word[`CALM_ST_INIT] = capacity_initial_low_flag;
		status_word[`CALM_ST_FINAL] = capacity_final_low_flag;
		status_word[`CALM_ST_DSG] = in_dsg;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= wb_req;
			dat_o <= 32'h00000000;
			if (wb_req && !we_i) begin
				unique case (wb_off)
					`CALM_OFF_LOAD_CFG: begin
						dat_o[`CALM_LDMODE_BIT] <= load_mode;
						dat_o[`CALM_LDSEL_LSB +: 3] <= load_sel;
					end
					`CALM_OFF_STATUS: dat_o <= {16'h0000, status_word};
					`CALM_OFF_INIT_SET: dat_o <= {16'h0000, init_set};
					`CALM_OFF_INIT_CLR: dat_o <= {16'h0000, init_clr};
					`CALM_OFF_FIN_SET: dat_o <= {16'h0000, fin_set};
					`CALM_OFF_FIN_CLR: dat_o <= {16'h0000, fin_clr};
					`CALM_OFF_RESERVE: dat_o <= {16'h0000, reserve_charge_setting};
					`CALM_OFF_DESIGN_CAP: dat_o <= {16'h0000, design_cap};
					`CALM_OFF_DESIGN_EN: dat_o <= {16'h0000, design_energy};
					`CALM_OFF_USER_MA: dat_o <= {16'h0000, user_rate_ma};
					`CALM_OFF_USER_MW: dat_o <= {16'h0000, user_rate_mw};
					`CALM_OFF_HOST_RATE: dat_o <= {16'h0000, host_rate_value};
					`CALM_OFF_REMAIN: dat_o <= {16'h0000, remaining_capacity_a};
					`CALM_OFF_LOAD_RATE: dat_o <= {16'h0000, load_rate};
					`CALM_OFF_AVG_CUR: dat_o <= {16'h0000, averaged_current};
					`CALM_OFF_PREV_AVG: dat_o <= {prev_avg[1], prev_avg[0]};
					`CALM_OFF_IRQ_STAT: dat_o <= {29'h00000000, irq_stat};
					`CALM_OFF_IRQ_MASK: dat_o <= {29'h00000000, irq_mask};
					`CALM_OFF_RAW_CAP: dat_o <= {16'h0000, raw_cap};
					default: dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_init_set: assert property (rc_valid && remaining_capacity_a < init_set // see R2
		|=> capacity_initial_low_flag) else $error("initial flag not set");
	a_init_clear: assert property (rc_valid && remaining_capacity_a >= init_set && // see R3
		remaining_capacity_a > init_clr |=> !capacity_initial_low_flag)
		else $error("initial flag not cleared");
	a_init_hold: assert property (!rc_valid |=> $stable(capacity_initial_low_flag)) // see R16
		else $error("initial flag moved without update");
	a_pin_follows: assert property (low_battery_pin_o == capacity_initial_low_flag) // see R4
		else $error("pin differs from initial flag");
	a_final_set: assert property (rc_valid && fin_set != 16'h0000 && // see R5
		remaining_capacity_a < fin_set |=> capacity_final_low_flag)
		else $error("final flag not set");
	a_final_off: assert property (rc_valid && fin_set == 16'h0000 // see R6
		|=> !capacity_final_low_flag) else $error("final flag set while disabled");
	a_final_clear: assert property (rc_valid && capacity_final_low_flag && // see R7
		remaining_capacity_a >= fin_set && remaining_capacity_a > fin_clr
		|=> !capacity_final_low_flag) else $error("final flag not cleared");
	a_model_mirror: assert property (wb_req && !we_i && wb_off == `CALM_OFF_STATUS // see R10
		|=> ack_o && dat_o[`CALM_ST_MODEL] == $past(load_mode))
		else $error("status does not mirror load model");
	a_user_rate: assert property (load_sel == 3'h6 && load_mode == 1'b0 // see R11
		##1 load_sel == 3'h6 && load_mode == 1'b0 |-> load_rate == $past(user_rate_ma))
		else $error("user rate not selected");
	a_reserve_floor: assert property (raw_cap <= reserve_charge_setting // see R15
		|=> remaining_capacity_a == 16'h0000) else $error("reserve not held back");
	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");

	c_init_low: cover property (rc_valid ##1 $rose(capacity_initial_low_flag));
	c_final_low: cover property (rc_valid ##1 $rose(capacity_final_low_flag));
	c_cycle_end: cover property (ev_cycle);
	c_irq_raise: cover property ($rose(irq_o));
endmodule

// ==== test/calm_meas_model.sv ====
// Converter-side model that delivers current and voltage samples
`timescale 1ns/1ps
module calm_meas_model (
	// Clock
	input wire logic clk_i,
	// Sample outputs
	output logic sample_valid_o,
	output logic signed [15:0] sense_current_o,
	output logic [15:0] cell_voltage_o
);
	initial begin
		sample_valid_o = 1'b0;
		sense_current_o = 16'h0000;
		cell_voltage_o = 16'h0E74;
	end

	// Spacing of 40 cycles leaves the divider time to finish between samples
	task automatic send(input logic signed [15:0] c);
		@(posedge clk_i);
		sample_valid_o <= 1'b1;
		sense_current_o <= c;
		@(posedge clk_i);
		sample_valid_o <= 1'b0;
		// Stale data is scrambled so a late sampler cannot pass by chance
		sense_current_o <= ~c;
		repeat (40) @(posedge clk_i);
	endtask
endmodule

// ==== test/tb.sv ====
// Register-level bench for the capacity alarm block
`timescale 1ns/1ps
`include "calm_params.svh"
module tb;
	logic clk_i;
	logic rst_i;
	logic cyc;
	logic stb;
	logic we;
	logic [7:0] adr;
	logic [31:0] dat;
	logic [3:0] sel;
	// Byte lanes for the next access
	logic [3:0] bsel;
	logic [31:0] rdat;
	logic ack;
	logic sv;
	logic signed [15:0] scur;
	logic [15:0] cvol;
	logic pin;
	logic irq;
	int error_cnt = 0;
	int n_compared = 0;

	calm_top dut_u (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc),
		.stb_i(stb),
		.we_i(we),
		.adr_i(adr),
		.sel_i(sel),
		.dat_i(dat),
		.dat_o(rdat),
		.ack_o(ack),
		.sample_valid_i(sv),
		.sense_current_i(scur),
		.cell_voltage_i(cvol),
		.low_battery_pin_o(pin),
		.irq_o(irq)
	);

	calm_meas_model meas_u (
		.clk_i(clk_i),
		.sample_valid_o(sv),
		.sense_current_o(scur),
		.cell_voltage_o(cvol)
	);

	task automatic summarize();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic cycle: request held until ack is seen at a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= bsel;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) begin
			error_cnt++;
			summarize();
		end
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		int rem;
		logic ei;
		logic ef;
		logic [31:0] cfg [11];
		logic [31:0] expr [11];
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		sel = 4'h0;
		bsel = 4'h3;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`CALM_OFF_LOAD_CFG, 32'hFFFF, 32'h0100);
		rd(`CALM_OFF_STATUS, 32'h7, 32'h0);
		rd(8'h4C, 32'hFFFFFFFF, 32'h0);
		wr(`CALM_OFF_INIT_SET, 32'hA);
		wr(`CALM_OFF_INIT_CLR, 32'h14);
		wr(`CALM_OFF_FIN_SET, 32'h5);
		wr(`CALM_OFF_FIN_CLR, 32'h8);
		wr(`CALM_OFF_RAW_CAP, 32'hC);
		rem = 12;
		ei = 1'b0;
		ef = 1'b0;
		// Nine 1 mAh discharge steps down to 3, then charge back up to 22
		for (int i = 0; i < 28; i++) begin
			meas_u.send((i < 9) ? -16'sd3600 : 16'sd3600);
			rem = rem + ((i < 9) ? -1 : 1);
			if (rem < 10) ei = 1'b1;
			else if (rem > 20) ei = 1'b0;
			if (rem < 5) ef = 1'b1;
			else if (ef && rem > 8) ef = 1'b0;
			rd(`CALM_OFF_REMAIN, 32'hFFFF, rem);
			rd(`CALM_OFF_STATUS, 32'h6, {29'h0, ef, ei, 1'b0});
			chk({31'h0, pin}, {31'h0, ei});
		end
		chk({31'h0, irq}, 32'h0);
		rd(`CALM_OFF_IRQ_STAT, 32'h7, 32'h7);
		wr(`CALM_OFF_IRQ_MASK, 32'h1);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		wr(`CALM_OFF_IRQ_STAT, 32'h7);
		repeat (3) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		rd(`CALM_OFF_IRQ_STAT, 32'h7, 32'h0);
		wr(`CALM_OFF_RAW_CAP, 32'h4);
		meas_u.send(-16'sd3600);
		rd(`CALM_OFF_STATUS, 32'h4, 32'h4);
		wr(`CALM_OFF_FIN_SET, 32'h0);
		meas_u.send(-16'sd3600);
		rd(`CALM_OFF_STATUS, 32'h4, 32'h0);
		wr(`CALM_OFF_RESERVE, 32'h5);
		wr(`CALM_OFF_RAW_CAP, 32'h14);
		meas_u.send(16'sd0);
		rd(`CALM_OFF_REMAIN, 32'hFFFF, 32'hF);
		wr(`CALM_OFF_RAW_CAP, 32'h3);
		meas_u.send(16'sd0);
		rd(`CALM_OFF_REMAIN, 32'hFFFF, 32'h0);
		wr(`CALM_OFF_DESIGN_CAP, 32'h3E8);
		wr(`CALM_OFF_DESIGN_EN, 32'h7D0);
		wr(`CALM_OFF_USER_MA, 32'h1C8);
		wr(`CALM_OFF_USER_MW, 32'h315);
		wr(`CALM_OFF_HOST_RATE, 32'h7B);
		cfg = '{32'h400, 32'h500, 32'h600, 32'h401, 32'h501, 32'h601, 32'h000, 32'h001,
			32'h100, 32'h101, 32'h700};
		expr = '{32'hC8, 32'h7B, 32'h1C8, 32'h190, 32'h7B, 32'h315, 32'hE10, 32'h534,
			32'hE10, 32'h534, 32'hE10};
		for (int k = 0; k < 11; k++) begin
			wr(`CALM_OFF_LOAD_CFG, cfg[k]);
			rd(`CALM_OFF_LOAD_RATE, 32'hFFFF, expr[k]);
			rd(`CALM_OFF_STATUS, 32'h1, cfg[k] & 32'h1);
		end
		rd(`CALM_OFF_PREV_AVG, 32'hFFFFFFFF, 32'h05340E10);
		bsel = 4'h1;
		wr(`CALM_OFF_HOST_RATE, 32'h0000AA55);
		bsel = 4'h3;
		rd(`CALM_OFF_HOST_RATE, 32'hFFFF, 32'h0055);
		summarize();
	end
endmodule
